// File: src/rtcsp_pkg.sv
// ----------------------------------------------------------------
// serial slave port constants and types
// ----------------------------------------------------------------
package rtcsp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 20000; // system clock rate in kHz
  localparam int unsigned TIMEOUT_MS = 1000; // bus timeout in ms
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned OSC_LOSS_US = 500; // oscillator silence limit in us
  localparam int unsigned OSC_LOSS_CYC = (OSC_LOSS_US * CLK_KHZ) / 1000;
  localparam int TMO_W = 25; // holds TIMEOUT_CYC
  localparam int OSC_W = 14; // holds OSC_LOSS_CYC

  // ----------------------------------------------------------------
  // protocol values
  // ----------------------------------------------------------------
  localparam logic [6:0] SLV_ADDR = 7'h51; // fixed 7-bit slave address
  localparam logic [3:0] BYTE_BITS = 4'h8; // bits per byte
  localparam logic [3:0] LAST_TX_BIT = 4'h7; // index of last sent bit
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] PTR_RST = 4'h0; // register pointer after reset
  localparam logic [3:0] PTR_STEP = 4'h1; // auto increment
  localparam logic [2:0] OSC_DIV_LAST = 3'h7; // last divider count before a toggle, one toggle per eight oscillator edges

  // states, gray along idle -> rx -> rxack -> tx -> txack -> ignore
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RXACK = 3'b011,
    ST_TX = 3'b010,
    ST_TXACK = 3'b110,
    ST_IGNORE = 3'b111
  } rtcsp_state_e;

  // register access toward the clock core
  typedef struct packed
  {
    logic we;
    logic re;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtcsp_req_s;

endpackage

// File: src/rtcsp_sync.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// three-stage input synchroniser with agreement filter
// ----------------------------------------------------------------
module rtcsp_sync
  import rtcsp_pkg::*;
#(
  parameter logic RST_VAL = 1'b0 // level held during reset
)
(
  input wire logic i_clk, // sampling clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_async, // level from another domain
  output logic o_level // filtered level
);

  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;

  // first stage feeds only the second; the filter looks at stages two and three
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ff1_reg <= RST_VAL;
      ff2_reg <= RST_VAL;
      ff3_reg <= RST_VAL;
    end
    else
    begin
      ff1_reg <= i_async;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // a change counts only once two stages agree, which rejects a one-sample glitch
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_level <= RST_VAL;
    else if (ff2_reg == ff3_reg)
      o_level <= ff3_reg;
  end

endmodule

// File: src/rtcsp_port.sv
`timescale 1ns/1ns
module rtcsp_port
  import rtcsp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC, // bus timeout in clocks
  parameter int unsigned OSC_LOSS_CYCLES = OSC_LOSS_CYC // oscillator loss limit
)
(
  input wire logic I_CLOCK, // system clock, 20 MHz
  input wire logic I_SRST, // synchronous reset, active high
  input wire logic I_OSC_CLOCK, // crystal oscillator clock
  input wire logic I_SCL_I, // serial clock line level
  output logic O_SCL_O, // serial clock drive value, always low
  output logic O_SCL_OE, // serial clock pull-down enable
  input wire logic I_SDA_I, // serial data line level
  output logic O_SDA_O, // serial data drive value, always low
  output logic O_SDA_OE, // serial data pull-down enable
  output rtcsp_req_s O_REQ, // register write or read strobe
  output logic [3:0] O_RD_PTR, // register index to present on read data
  input wire logic [7:0] I_REG_RDATA, // register content at O_RD_PTR
  output logic O_BUS_BUSY, // transaction open
  output logic O_BUS_TIMEOUT, // last transaction hit the timeout
  output logic O_OSC_OK // oscillator seen running
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  rtcsp_state_e state_reg;
  rtcsp_req_s req_reg;
  logic scl_q;
  logic sda_q;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic sda_oe_reg;
  logic rw_reg;
  logic addr_phase_reg;
  logic ptr_set_reg;
  logic [3:0] ptr_reg;
  logic nack_reg;
  logic busy_reg;
  logic timeout_reg;
  logic [TMO_W-1:0] tmo_cnt_reg;
  logic tmo_hit;
  logic osc_rst1_reg;
  logic osc_rst2_reg;
  logic [2:0] osc_div_reg;
  logic osc_tgl_reg;
  logic osc_tgl_q;
  logic osc_tgl_prev_reg;
  logic [OSC_W-1:0] osc_wd_reg;
  logic osc_ok_reg;

  // pointer step with wrap from the top register back to zero
  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    ptr_inc = p + PTR_STEP;
  endfunction

  // ----------------------------------------------------------------
  // oscillator domain: divided toggle for the activity monitor
  // ----------------------------------------------------------------

  // reset brought over as a level; held many cycles so the late edge is harmless
  always_ff @(posedge I_OSC_CLOCK)
  begin
    osc_rst1_reg <= I_SRST;
    osc_rst2_reg <= osc_rst1_reg;
  end

  // toggling every eighth edge keeps the crossing slow enough to sample
  always_ff @(posedge I_OSC_CLOCK)
  begin
    if (osc_rst2_reg)
    begin
      osc_div_reg <= 3'h0;
      osc_tgl_reg <= 1'b0;
    end
    else
    begin
      osc_div_reg <= osc_div_reg + 3'h1;
      if (osc_div_reg == OSC_DIV_LAST)
        osc_tgl_reg <= ~osc_tgl_reg;
    end
  end

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  rtcsp_sync #(.RST_VAL(1'b1)) u_scl_sync
  (
    .i_clk(I_CLOCK),
    .i_rst(I_SRST),
    .i_async(I_SCL_I),
    .o_level(scl_q)
  );

  rtcsp_sync #(.RST_VAL(1'b1)) u_sda_sync
  (
    .i_clk(I_CLOCK),
    .i_rst(I_SRST),
    .i_async(I_SDA_I),
    .o_level(sda_q)
  );

  rtcsp_sync #(.RST_VAL(1'b0)) u_osc_sync
  (
    .i_clk(I_CLOCK),
    .i_rst(I_SRST),
    .i_async(osc_tgl_reg),
    .o_level(osc_tgl_q)
  );

  // ----------------------------------------------------------------
  // oscillator watch
  // ----------------------------------------------------------------

  // no toggle for the loss limit means the crystal has stopped
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      osc_tgl_prev_reg <= 1'b0;
      osc_wd_reg <= '0;
      osc_ok_reg <= 1'b0;
    end
    else
    begin
      osc_tgl_prev_reg <= osc_tgl_q;
      if (osc_tgl_q != osc_tgl_prev_reg)
      begin
        osc_wd_reg <= '0;
        osc_ok_reg <= 1'b1;
      end
      else if (osc_wd_reg == OSC_W'(OSC_LOSS_CYCLES))
        osc_ok_reg <= 1'b0;
      else
        osc_wd_reg <= osc_wd_reg + OSC_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // line events
  // ----------------------------------------------------------------

  // previous filtered levels for edge and condition detection
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_q;
      sda_prev_reg <= sda_q;
    end
  end

  assign scl_rise = scl_q & ~scl_prev_reg;
  assign scl_fall = ~scl_q & scl_prev_reg;
  // data moving under a steady high clock is a condition, not data
  assign start_evt = scl_q & scl_prev_reg & sda_prev_reg & ~sda_q;
  assign stop_evt = scl_q & scl_prev_reg & ~sda_prev_reg & sda_q;

  // ----------------------------------------------------------------
  // bus timeout
  // ----------------------------------------------------------------
  assign tmo_hit = busy_reg && (tmo_cnt_reg == TMO_W'(TIMEOUT_CYCLES - 1));

  // a repeated start does not restart the clock on the transaction
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      busy_reg <= 1'b0;
      tmo_cnt_reg <= '0;
      timeout_reg <= 1'b0;
    end
    else
    begin
      if (!osc_ok_reg || stop_evt || tmo_hit)
        busy_reg <= 1'b0;
      else if (start_evt)
        busy_reg <= 1'b1;
      if (!busy_reg)
        tmo_cnt_reg <= '0;
      else
        tmo_cnt_reg <= tmo_cnt_reg + TMO_W'(1);
      if (tmo_hit)
        timeout_reg <= 1'b1;
      else if (start_evt && osc_ok_reg)
        timeout_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transfer state machine
  // ----------------------------------------------------------------

  // standby on timeout or stopped crystal takes priority over every event
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= BIT_ZERO;
      shift_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      addr_phase_reg <= 1'b0;
      ptr_set_reg <= 1'b0;
      ptr_reg <= PTR_RST;
      nack_reg <= 1'b0;
      req_reg <= '0;
    end
    else
    begin
      req_reg.we <= 1'b0;
      req_reg.re <= 1'b0;
      if (!osc_ok_reg || tmo_hit)
      begin
        state_reg <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end
      else if (start_evt)
      begin
        state_reg <= ST_RX;
        bit_cnt_reg <= BIT_ZERO;
        addr_phase_reg <= 1'b1;
        sda_oe_reg <= 1'b0;
      end
      else if (stop_evt)
      begin
        state_reg <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_RX:
          begin
            if (scl_rise && bit_cnt_reg < BYTE_BITS)
            begin
              shift_reg <= {shift_reg[6:0], sda_q};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (scl_fall && bit_cnt_reg == BYTE_BITS)
            begin
              bit_cnt_reg <= BIT_ZERO;
              if (addr_phase_reg)
              begin
                addr_phase_reg <= 1'b0;
                if (shift_reg[7:1] == SLV_ADDR)
                begin
                  rw_reg <= shift_reg[0];
                  ptr_set_reg <= 1'b0;
                  sda_oe_reg <= 1'b1;
                  state_reg <= ST_RXACK;
                end
                else
                  state_reg <= ST_IGNORE;
              end
              else
              begin
                sda_oe_reg <= 1'b1;
                state_reg <= ST_RXACK;
                if (!ptr_set_reg)
                begin
                  ptr_reg <= shift_reg[3:0];
                  ptr_set_reg <= 1'b1;
                end
                else
                begin
                  req_reg.we <= 1'b1;
                  req_reg.addr <= ptr_reg;
                  req_reg.wdata <= shift_reg;
                  ptr_reg <= ptr_inc(ptr_reg);
                end
              end
            end
          end
          ST_RXACK:
          begin
            if (scl_fall)
            begin
              if (rw_reg)
              begin
                // first read byte comes from the pointer left by earlier access
                shift_reg <= I_REG_RDATA;
                sda_oe_reg <= ~I_REG_RDATA[7];
                req_reg.re <= 1'b1;
                req_reg.addr <= ptr_reg;
                ptr_reg <= ptr_inc(ptr_reg);
                state_reg <= ST_TX;
              end
              else
              begin
                sda_oe_reg <= 1'b0;
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              if (bit_cnt_reg == LAST_TX_BIT)
              begin
                sda_oe_reg <= 1'b0;
                bit_cnt_reg <= BIT_ZERO;
                state_reg <= ST_TXACK;
              end
              else
              begin
                shift_reg <= {shift_reg[6:0], 1'b1};
                sda_oe_reg <= ~shift_reg[6];
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_TXACK:
          begin
            if (scl_rise)
              nack_reg <= sda_q;
            if (scl_fall)
            begin
              if (!nack_reg)
              begin
                shift_reg <= I_REG_RDATA;
                sda_oe_reg <= ~I_REG_RDATA[7];
                req_reg.re <= 1'b1;
                req_reg.addr <= ptr_reg;
                ptr_reg <= ptr_inc(ptr_reg);
                state_reg <= ST_TX;
              end
              else
                state_reg <= ST_IGNORE; // master ended the read, wait for stop
            end
          end
          default:
          begin
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // open-drain: the value is always low, only the enable moves
  assign O_SDA_O = 1'b0;
  assign O_SDA_OE = sda_oe_reg;
  // the port never stretches the clock
  assign O_SCL_O = 1'b0;
  assign O_SCL_OE = 1'b0;
  assign O_REQ = req_reg;
  assign O_RD_PTR = ptr_reg;
  assign O_BUS_BUSY = busy_reg;
  assign O_BUS_TIMEOUT = timeout_reg;
  assign O_OSC_OK = osc_ok_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_idle_released: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    (state_reg == ST_IDLE || state_reg == ST_IGNORE) |-> !sda_oe_reg)
    else $error("data line pulled while not addressed");

  a_start_enters_rx: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    (start_evt && osc_ok_reg && !tmo_hit) |=> (state_reg == ST_RX && bit_cnt_reg == BIT_ZERO
    && addr_phase_reg))
    else $error("start condition not taken");

  a_stop_to_idle: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    (stop_evt && !start_evt) |=> (state_reg == ST_IDLE && !sda_oe_reg))
    else $error("stop condition did not end the transfer");

  a_drive_on_low: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    $rose(sda_oe_reg) |-> !$past(scl_q))
    else $error("data line changed while clock high");

  a_bit_per_pulse: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    (state_reg == ST_RX && scl_rise && bit_cnt_reg < BYTE_BITS && osc_ok_reg && !tmo_hit
    && !start_evt && !stop_evt) |=> (bit_cnt_reg == $past(bit_cnt_reg) + 4'h1))
    else $error("bit count did not follow clock pulse");

  a_addr_mismatch: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    (state_reg == ST_RX && addr_phase_reg && scl_fall && bit_cnt_reg == BYTE_BITS
    && shift_reg[7:1] != SLV_ADDR && osc_ok_reg && !tmo_hit && !start_evt && !stop_evt)
    |=> (state_reg == ST_IGNORE) [*2])
    else $error("foreign address answered");

  a_timeout_standby: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    tmo_hit |=> (state_reg == ST_IDLE && !busy_reg && timeout_reg && !req_reg.we))
    else $error("timeout did not return to standby");

  a_osc_silent: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    !osc_ok_reg |=> (state_reg == ST_IDLE && !sda_oe_reg))
    else $error("port active with oscillator stopped");

  a_ptr_advance: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    (req_reg.we || req_reg.re) |-> (ptr_reg == ptr_inc(req_reg.addr)))
    else $error("pointer did not advance after byte");

  a_ack_ninth: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    (state_reg == ST_RX && !addr_phase_reg && scl_fall && bit_cnt_reg == BYTE_BITS
    && osc_ok_reg && !tmo_hit && !start_evt && !stop_evt)
    |=> (sda_oe_reg && state_reg == ST_RXACK))
    else $error("received byte not acknowledged");

endmodule

// File: bench/rtcsp_master.sv
`timescale 1ns/1ns
// ----------------
// bus master model
// ----------------
module rtcsp_master
  import rtcsp_pkg::*;
#(
  parameter int QTR = 10 // quarter of a serial bit in clocks
)
(
  input wire logic i_clk, // bench system clock
  input wire logic i_sda, // resolved serial data line
  output logic o_scl_oe, // pull serial clock low
  output logic o_sda_oe // pull serial data low
);
  // lines start released so the pull-ups hold them high
  initial
  begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end

  task automatic qwait();
    repeat (QTR) @(posedge i_clk);
  endtask

  // start or repeated start: data falls while clock stays high
  task automatic start_cond();
    o_sda_oe <= 1'b0;
    qwait();
    o_scl_oe <= 1'b0;
    qwait();
    o_sda_oe <= 1'b1;
    qwait();
    o_scl_oe <= 1'b1;
    qwait();
  endtask

  // stop: data rises while clock is high, then the bus is idle
  task automatic stop_cond();
    o_sda_oe <= 1'b1;
    qwait();
    o_scl_oe <= 1'b0;
    qwait();
    o_sda_oe <= 1'b0;
    qwait();
  endtask

  // data set mid-low and read mid-high; lines only pulled or released
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe <= !b;
    qwait();
    o_scl_oe <= 1'b0;
    qwait();
    r = i_sda;
    qwait();
    o_scl_oe <= 1'b1;
    qwait();
  endtask

  // one byte msb first, then the ninth acknowledge bit
  task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
    output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(ack_in, ack_out);
  endtask
endmodule

// File: bench/tb_rtc_i2c_slave_port.sv
`timescale 1ns/1ns
// ----------------------------
// bench for the serial port
// ----------------------------
module tb_rtc_i2c_slave_port;
  import rtcsp_pkg::*;

  localparam int unsigned TMO = 4000; // shortened bus timeout; normal scenarios stay well
  localparam int unsigned OSC_LOSS = 100; // shortened oscillator loss limit
  localparam int LIMIT = 40000; // run ceiling in clocks

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic osc_clk = 1'b0;
  logic osc_run = 1'b1;
  logic m_scl_oe;
  logic m_sda_oe;
  logic d_scl_o;
  logic d_scl_oe;
  logic d_sda_o;
  logic d_sda_oe;
  rtcsp_req_s req;
  logic [3:0] rd_ptr;
  logic busy;
  logic tmo;
  logic osc_ok;
  logic bad_drive = 1'b0;
  logic [7:0] regs [16];
  int n_fail = 0;
  int tests_run = 0;
  int n_we = 0;
  int n_re = 0;
  int cyc = 0;

  // open-drain wires: low if anyone pulls
  wire logic scl_line = !(m_scl_oe || d_scl_oe);
  wire logic sda_line = !(m_sda_oe || d_sda_oe);
  wire logic [7:0] rdata = regs[rd_ptr];

  always #25 clk = ~clk;
  // oscillator can be halted to model a stopped crystal
  always #15 if (osc_run) osc_clk = ~osc_clk;

  rtcsp_port #(.TIMEOUT_CYCLES(TMO), .OSC_LOSS_CYCLES(OSC_LOSS)) rtcsp_port_inst (
    .I_CLOCK(clk), .I_SRST(srst), .I_OSC_CLOCK(osc_clk),
    .I_SCL_I(scl_line), .O_SCL_O(d_scl_o), .O_SCL_OE(d_scl_oe),
    .I_SDA_I(sda_line), .O_SDA_O(d_sda_o), .O_SDA_OE(d_sda_oe),
    .O_REQ(req), .O_RD_PTR(rd_ptr), .I_REG_RDATA(rdata),
    .O_BUS_BUSY(busy), .O_BUS_TIMEOUT(tmo), .O_OSC_OK(osc_ok));

  rtcsp_master #(.QTR(10)) rtcsp_master_inst (
    .i_clk(clk), .i_sda(sda_line), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));

  // register file model, plus a watch that the port never drives high
  always @(posedge clk)
  begin
    if (req.we === 1'b1)
    begin
      regs[req.addr] <= req.wdata;
      n_we <= n_we + 1;
    end
    if (req.re === 1'b1)
      n_re <= n_re + 1;
    if (!srst && (d_scl_oe !== 1'b0 || d_scl_o !== 1'b0 || d_sda_o !== 1'b0))
      bad_drive <= 1'b1;
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_osc();
    int n;
    n = 0;
    while (osc_ok !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  // send a byte, judge the acknowledge level
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic [7:0] r;
    logic a;
    rtcsp_master_inst.xbyte(d, 1'b1, r, a);
    check("ack", {7'h00, a}, {7'h00, exp_ack});
  endtask

  // read a byte, answer ack or nack, judge the data
  task automatic recv(input logic [7:0] exp, input logic nack);
    logic [7:0] r;
    logic a;
    rtcsp_master_inst.xbyte(8'hFF, nack, r, a);
    check("read byte", r, exp);
  endtask

  task automatic t_idle();
    check("osc ok", {7'h00, osc_ok}, 8'h01);
    check("scl drive", {6'h00, d_scl_oe, d_scl_o}, 8'h00);
    check("sda drive", {6'h00, d_sda_oe, d_sda_o}, 8'h00);
  endtask

  // three writes from Eh show the pointer wrap
  task automatic t_write();
    int we0;
    we0 = n_we;
    rtcsp_master_inst.start_cond();
    send(8'hA2, 1'b0);
    check("busy", {7'h00, busy}, 8'h01);
    send(8'h0E, 1'b0);
    send(8'hAA, 1'b0);
    send(8'h55, 1'b0);
    send(8'h3C, 1'b0);
    rtcsp_master_inst.stop_cond();
    check("busy", {7'h00, busy}, 8'h00);
    check("reg e", regs[14], 8'hAA);
    check("reg f", regs[15], 8'h55);
    check("reg 0", regs[0], 8'h3C);
    check("writes", 8'(n_we - we0), 8'h03);
  endtask

  // pointer write, repeated start, read back across the wrap
  task automatic t_read();
    int re0;
    re0 = n_re;
    rtcsp_master_inst.start_cond();
    send(8'hA2, 1'b0);
    send(8'h0E, 1'b0);
    rtcsp_master_inst.start_cond();
    send(8'hA3, 1'b0);
    recv(8'hAA, 1'b0);
    recv(8'h55, 1'b0);
    recv(8'h3C, 1'b1);
    rtcsp_master_inst.stop_cond();
    rtcsp_master_inst.start_cond();
    send(8'hA3, 1'b0);
    recv(8'hA1, 1'b1);
    rtcsp_master_inst.stop_cond();
    check("reads", 8'(n_re - re0), 8'h04);
  endtask

  // foreign address, then a stop in mid-byte
  task automatic t_ignore();
    int we0;
    logic a;
    we0 = n_we;
    rtcsp_master_inst.start_cond();
    send(8'hA4, 1'b1);
    send(8'h02, 1'b1);
    send(8'h99, 1'b1);
    rtcsp_master_inst.stop_cond();
    rtcsp_master_inst.start_cond();
    send(8'hA2, 1'b0);
    send(8'h05, 1'b0);
    for (int i = 0; i < 4; i++)
      rtcsp_master_inst.bit_io(1'b0, a);
    rtcsp_master_inst.stop_cond();
    check("busy", {7'h00, busy}, 8'h00);
    check("reg 5", regs[5], 8'hA5);
    check("writes", 8'(n_we - we0), 8'h00);
  endtask

  // overlong transaction: writes dropped, reads all ones, fresh start recovers
  task automatic t_timeout();
    rtcsp_master_inst.start_cond();
    send(8'hA2, 1'b0);
    send(8'h03, 1'b0);
    repeat (TMO + 200) @(posedge clk);
    check("timeout", {7'h00, tmo}, 8'h01);
    check("busy", {7'h00, busy}, 8'h00);
    send(8'h77, 1'b1);
    recv(8'hFF, 1'b1);
    rtcsp_master_inst.stop_cond();
    check("reg 3", regs[3], 8'hA3);
    rtcsp_master_inst.start_cond();
    check("timeout", {7'h00, tmo}, 8'h00);
    send(8'hA2, 1'b0);
    send(8'h03, 1'b0);
    send(8'h77, 1'b0);
    rtcsp_master_inst.stop_cond();
    check("reg 3", regs[3], 8'h77);
  endtask

  // halted crystal: no answer until it runs again
  task automatic t_osc();
    int we0;
    we0 = n_we;
    osc_run <= 1'b0;
    repeat (OSC_LOSS * 3) @(posedge clk);
    check("osc ok", {7'h00, osc_ok}, 8'h00);
    rtcsp_master_inst.start_cond();
    send(8'hA2, 1'b1);
    send(8'h06, 1'b1);
    rtcsp_master_inst.stop_cond();
    check("writes", 8'(n_we - we0), 8'h00);
    osc_run <= 1'b1;
    wait_osc();
    check("osc ok", {7'h00, osc_ok}, 8'h01);
  endtask

  initial
  begin
    for (int i = 0; i < 16; i++)
      regs[i] = 8'hA0 + 8'(i);
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    wait_osc();
    repeat (2) @(posedge clk);
    t_idle();
    t_write();
    t_read();
    t_ignore();
    t_timeout();
    t_osc();
    check("drive high", {7'h00, bad_drive}, 8'h00);
    close_out();
  end
endmodule
